// ### hw/codec_ports_pkg.sv
// Constants shared by the codec digital port logic
package codec_ports_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PCM_TX = 8'h08;
  localparam logic [7:0] ADDR_PCM_RX = 8'h0C;
  localparam logic [7:0] ADDR_UP_TX = 8'h10;
  localparam logic [7:0] ADDR_UP_RX = 8'h14;
  // Control register field positions
  localparam int CTRL_LAW_A = 0;
  localparam int CTRL_FP_MODE = 1;
  localparam int CTRL_DCHAN_EN = 2;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_UP_REPLY = 4;
  localparam int CTRL_WIDTH = 5;
  // Status register field positions
  localparam int STAT_LAW_EFF = 0;
  localparam int STAT_IRQ = 1;
  localparam int STAT_RATE_LSB = 16;
  // Reset values: strobed mode, mu-law, split wire off, all data clear
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Default PCM rate reported in status, kb/s
  localparam logic [15:0] PCM_RATE_KBPS = 16'h0800;
  // Slot and frame counts in bit clocks
  localparam logic [7:0] SLOT_BITS = 8'h08;
  localparam logic [7:0] DLY_CHANNELS = 8'h04;
  localparam logic [7:0] DLY_FP_BIT = 8'(DLY_CHANNELS * SLOT_BITS);
  localparam logic [7:0] STB_RUN_LAST = 8'(2 * SLOT_BITS - 1);
  localparam logic [2:0] UP_LAST = 3'h7;
  localparam logic [2:0] PCM_LAST = 3'h7;
endpackage

// ### hw/codec_digital_ports.sv
// Codec digital ports: PCM link, serial microport, law/interrupt pin
// What this block does
// - Power-up reset returns all state to initial
// - Enable low: pin selects law, ORed with bit
// - Enable high: pin is open-drain access interrupt, raised in bus mode only
// - Microport data timed by host serial clock
// - Split wire: out on data1, in on data2
// - Single wire: both ways on data1, data2 ignored
// - Drive 8 slot bits out on rising edges
// - Sample 8 slot bits on falling edges
// - Delayed strobe, or frame pulse four slots later
// - Reset defaults strobed mode, 2048 kb/s, mu-law
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module codec_digital_ports
  import codec_ports_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic power_up_reset_n, // Power-up reset pin, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic law_irq_in, // Law select pin, input side
  output logic law_irq_out, // Interrupt pin level, always low
  output logic law_irq_oe_n, // Interrupt pin enable, low drives
  output logic law_is_a, // Effective law, high for A-law
  input wire logic cs_n, // Microport chip select, active low
  input wire logic sclk, // Microport serial clock
  input wire logic data1_in, // Primary data pin, input side
  output logic data1_out, // Primary data pin, output side
  output logic data1_oe_n, // Primary data pin enable, low drives
  input wire logic data2_in, // Secondary data pin
  input wire logic bit_clk, // PCM bit clock, link domain
  input wire logic slot_strobe_in, // Slot strobe or frame pulse
  input wire logic pcm_in, // PCM receive data
  output logic pcm_out, // PCM transmit data
  output logic pcm_oe_n, // PCM output enable, low drives
  output logic delayed_strobe_out // Cascade strobe or frame pulse
);

  // System domain state
  typedef struct packed {
    logic law_a, fp_mode, dchan_en, split, up_reply, irq_pend, law_eff;
    logic [7:0] pcm_tx, pcm_rx, up_tx, up_rx, up_sh;
    logic [2:0] up_cnt;
    logic up_out, tx_tog, rxt_s1, rxt_s2, rxt_p, pur_s1, pur_s2, law_s1, law_s2;
    logic cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_p, d1_s1, d1_s2, d2_s1, d2_s2, ack;
    logic [31:0] dat;
  } sys_t;

  // Link domain state, rising bit clock
  typedef struct packed {
    logic fp_s1, fp_s2, pur_s1, pur_s2, tt_s1, tt_s2, tt_p, strb_p, run;
    logic [7:0] cnt, tx_hold, sh;
    logic out_bit, out_en, dly;
  } lnk_t;

  // Link receive state, falling bit clock
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] n;
    logic [7:0] rx_byte;
    logic tog;
  } rxn_t;

  sys_t q, d;
  lnk_t lq, ld;
  rxn_t nq, nd;
  logic bus_req, bus_wr, sclk_rise, sclk_fall, up_bit;
  logic up_byte_done, irq_set, irq_clr, fp, start;

  // Bus decode; write lands on the ack edge, as the master samples it
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & q.ack & wb_sel_i[0];
  assign sclk_rise = q.sclk_s2 & ~q.sclk_p;
  assign sclk_fall = ~q.sclk_s2 & q.sclk_p;
  // Receive pin depends on wiring mode
  assign up_bit = q.split ? q.d2_s2 : q.d1_s2;
  assign up_byte_done = sclk_rise & ~q.cs_s2 & (q.up_cnt == UP_LAST);
  // A complete byte in bus mode counts as a valid channel access
  assign irq_set = up_byte_done & q.dchan_en & q.fp_mode;
  assign irq_clr = bus_wr & (wb_adr_i == ADDR_STATUS) & wb_dat_i[STAT_IRQ];

  // System next state
  always_comb
  begin
    d = q;
    d.pur_s1 = power_up_reset_n;
    d.pur_s2 = q.pur_s1;
    d.law_s1 = law_irq_in;
    d.law_s2 = q.law_s1;
    d.cs_s1 = cs_n;
    d.cs_s2 = q.cs_s1;
    d.sclk_s1 = sclk;
    d.sclk_s2 = q.sclk_s1;
    d.sclk_p = q.sclk_s2;
    d.d1_s1 = data1_in;
    d.d1_s2 = q.d1_s1;
    d.d2_s1 = data2_in;
    d.d2_s2 = q.d2_s1;
    d.rxt_s1 = nq.tog;
    d.rxt_s2 = q.rxt_s1;
    d.rxt_p = q.rxt_s2;
    // Single-cycle ack, dropped the cycle after
    d.ack = bus_req & ~q.ack;
    d.dat = 32'h0000_0000;
    if (bus_req & ~q.ack)
    begin
      case (wb_adr_i)
        ADDR_CTRL: d.dat[CTRL_WIDTH-1:0] = {q.up_reply, q.split, q.dchan_en, q.fp_mode, q.law_a};
        ADDR_STATUS:
        begin
          d.dat[STAT_LAW_EFF] = q.law_eff;
          d.dat[STAT_IRQ] = q.irq_pend;
          d.dat[STAT_RATE_LSB +: 16] = PCM_RATE_KBPS;
        end
        ADDR_PCM_TX: d.dat[7:0] = q.pcm_tx;
        ADDR_PCM_RX: d.dat[7:0] = q.pcm_rx;
        ADDR_UP_TX: d.dat[7:0] = q.up_tx;
        ADDR_UP_RX: d.dat[7:0] = q.up_rx;
        default: d.dat = 32'h0000_0000;
      endcase
    end
    // Register writes
    if (bus_wr)
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          d.law_a = wb_dat_i[CTRL_LAW_A];
          d.fp_mode = wb_dat_i[CTRL_FP_MODE];
          d.dchan_en = wb_dat_i[CTRL_DCHAN_EN];
          d.split = wb_dat_i[CTRL_SPLIT];
          d.up_reply = wb_dat_i[CTRL_UP_REPLY];
        end
        ADDR_PCM_TX:
        begin
          d.pcm_tx = wb_dat_i[7:0];
          d.tx_tog = ~q.tx_tog; // Tells the link a new word stands
        end
        ADDR_UP_TX: d.up_tx = wb_dat_i[7:0];
        default: d.up_tx = q.up_tx;
      endcase
    end
    // Set beats clear in the same cycle
    d.irq_pend = irq_set | (q.irq_pend & ~irq_clr);
    // Pin only counts as law input while it is not the interrupt
    d.law_eff = q.dchan_en ? q.law_a : (q.law_s2 | q.law_a);
    // Received PCM byte is stable long before the toggle arrives
    if (q.rxt_s2 != q.rxt_p)
    begin
      d.pcm_rx = nq.rx_byte;
    end
    // Microport shifter, idle while deselected
    if (q.cs_s2)
    begin
      d.up_cnt = 3'h0;
      d.up_out = q.up_tx[UP_LAST];
    end
    else
    begin
      if (sclk_rise)
      begin
        d.up_sh = {q.up_sh[6:0], up_bit};
        d.up_cnt = q.up_cnt + 3'h1;
        if (q.up_cnt == UP_LAST)
        begin
          d.up_rx = {q.up_sh[6:0], up_bit};
        end
      end
      if (sclk_fall)
      begin
        d.up_out = q.up_tx[UP_LAST - q.up_cnt];
      end
    end
    // Power-up reset pin clears all control and data state
    if (!q.pur_s2)
    begin
      {d.up_reply, d.split, d.dchan_en, d.fp_mode, d.law_a} = CTRL_RST;
      d.irq_pend = 1'b0;
      d.pcm_tx = BYTE_RST;
      d.pcm_rx = BYTE_RST;
      d.up_tx = BYTE_RST;
      d.up_rx = BYTE_RST;
      d.up_sh = BYTE_RST;
      d.up_cnt = 3'h0;
      d.up_out = 1'b0;
    end
  end

  // System registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  // Link start: strobe rise, or frame pulse fall in bus mode
  assign fp = lq.fp_s2;
  assign start = fp ? (~slot_strobe_in & lq.strb_p) : (slot_strobe_in & ~lq.strb_p);

  // Link next state
  always_comb
  begin
    ld = lq;
    ld.fp_s1 = q.fp_mode;
    ld.fp_s2 = lq.fp_s1;
    ld.pur_s1 = power_up_reset_n;
    ld.pur_s2 = lq.pur_s1;
    ld.tt_s1 = q.tx_tog;
    ld.tt_s2 = lq.tt_s1;
    ld.tt_p = lq.tt_s2;
    ld.strb_p = slot_strobe_in;
    if (lq.tt_s2 != lq.tt_p)
    begin
      ld.tx_hold = q.pcm_tx;
    end
    if (start)
    begin
      ld.run = 1'b1;
      ld.cnt = 8'h00;
      ld.out_bit = lq.tx_hold[7];
      ld.sh = {lq.tx_hold[6:0], 1'b0};
    end
    else if (lq.run)
    begin
      // Frame mode counter wraps with the frame and keeps running
      ld.cnt = lq.cnt + 8'h01;
      ld.out_bit = lq.sh[7];
      ld.sh = {lq.sh[6:0], 1'b0};
      if (!fp && (lq.cnt == STB_RUN_LAST))
      begin
        ld.run = 1'b0;
      end
    end
    ld.out_en = ld.run & (ld.cnt < SLOT_BITS);
    // Cascade output: 8-bit strobe after ours, or a low frame pulse
    if (fp)
      ld.dly = ~(ld.run & (ld.cnt == DLY_FP_BIT));
    else
      ld.dly = ld.run & (ld.cnt >= SLOT_BITS);
    if (!lq.pur_s2)
    begin
      ld.run = 1'b0;
      ld.cnt = 8'h00;
      ld.out_en = 1'b0;
      ld.dly = 1'b0;
      ld.tx_hold = BYTE_RST;
      ld.sh = BYTE_RST;
      ld.out_bit = 1'b0;
    end
  end

  // Link registers, rising edge
  always_ff @(posedge bit_clk or posedge sys_rst)
  begin
    if (sys_rst)
      lq <= '0;
    else
      lq <= ld;
  end

  // Receive shifter: samples mid-bit while our slot drives
  always_comb
  begin
    nd = nq;
    if (lq.out_en)
    begin
      nd.sh = {nq.sh[6:0], pcm_in};
      nd.n = nq.n + 3'h1;
      if (nq.n == PCM_LAST)
      begin
        nd.rx_byte = {nq.sh[6:0], pcm_in};
        nd.tog = ~nq.tog;
      end
    end
    else
    begin
      nd.n = 3'h0;
    end
  end

  // Link registers, falling edge
  always_ff @(negedge bit_clk or posedge sys_rst)
  begin
    if (sys_rst)
      nq <= '0;
    else
      nq <= nd;
  end

  // Outputs
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign law_is_a = q.law_eff;
  assign law_irq_out = 1'b0;
  assign law_irq_oe_n = ~(q.dchan_en & q.irq_pend);
  assign data1_out = q.up_out;
  // Split wire drives whenever selected; single wire only when replying
  assign data1_oe_n = q.cs_s2 | ~(q.split | q.up_reply);
  assign pcm_out = lq.out_bit;
  assign pcm_oe_n = ~lq.out_en;
  assign delayed_strobe_out = lq.dly;

  // Checks on the system side
  a_pur_clears: assert property (@(posedge clock) disable iff (sys_rst)
    !q.pur_s2 |=> (!q.law_a && !q.fp_mode && !q.irq_pend && q.up_cnt == 3'h0))
    else $error("power-up reset left state set");
  a_law_pin_or: assert property (@(posedge clock) disable iff (sys_rst)
    (!q.dchan_en && q.law_s2) |=> law_is_a)
    else $error("law pin high did not select A-law");
  a_pin_is_input: assert property (@(posedge clock) disable iff (sys_rst)
    !q.dchan_en |-> law_irq_oe_n)
    else $error("law pin driven while enable low");
  a_irq_access_drive: assert property (@(posedge clock) disable iff (sys_rst)
    (irq_set && q.pur_s2 && $stable(q.dchan_en)) |=> (q.dchan_en -> !law_irq_oe_n))
    else $error("valid access did not raise interrupt");
  a_cs_ignores: assert property (@(posedge clock) disable iff (sys_rst)
    q.cs_s2 |=> q.up_cnt == 3'h0)
    else $error("shifter moved while deselected");
  a_sclk_counts: assert property (@(posedge clock) disable iff (sys_rst)
    (sclk_rise && !q.cs_s2 && q.pur_s2) |=> q.up_cnt == $past(q.up_cnt) + 3'h1)
    else $error("serial clock edge not counted");
  a_split_drives: assert property (@(posedge clock) disable iff (sys_rst)
    (q.split && !q.cs_s2) |-> !data1_oe_n)
    else $error("split wire not driving data1");
  a_single_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (!q.split && !q.up_reply) |-> data1_oe_n)
    else $error("single wire drove data1 unasked");
  a_reset_mode: assert property (@(posedge clock)
    $fell(sys_rst) |-> (!q.fp_mode && !q.law_a))
    else $error("reset mode not strobed mu-law");

  // Checks on the link side
  a_slot_eight: assert property (@(posedge bit_clk) disable iff (sys_rst)
    ($fell(pcm_oe_n) && lq.pur_s2 && lq.pur_s1) |-> (!pcm_oe_n)[*8] ##1 pcm_oe_n)
    else $error("slot not eight bits wide");
  a_rx_byte: assert property (@(negedge bit_clk) disable iff (sys_rst)
    (lq.out_en && nq.n == PCM_LAST) |=> nq.tog != $past(nq.tog))
    else $error("eighth sample did not complete byte");
  a_fp_delay: assert property (@(posedge bit_clk) disable iff (sys_rst)
    (lq.fp_s2 && ld.fp_s2 && lq.run && !start && lq.pur_s2 && ld.pur_s2 &&
     lq.cnt == DLY_FP_BIT - 8'h01) |=> !delayed_strobe_out)
    else $error("cascade frame pulse missing");

  // Main scenarios
  c_up_byte: cover property (@(posedge clock) disable iff (sys_rst) up_byte_done);
  c_irq_pin: cover property (@(posedge clock) disable iff (sys_rst) !law_irq_oe_n);
  c_pcm_rx: cover property (@(posedge clock) disable iff (sys_rst) q.rxt_s2 != q.rxt_p);
  c_split_tx: cover property (@(posedge clock) disable iff (sys_rst) q.split && !data1_oe_n);

endmodule
`default_nettype wire

// ### bench/pcm_far_end.sv
// Layer 1 transceiver model: one PCM slot per requested frame
`timescale 1ns/1ps
`default_nettype none
module pcm_far_end (
  input wire logic bit_clk, // Link bit clock
  input wire logic go, // Rising edge starts a frame
  input wire logic bus_mode, // High for frame pulse timing
  input wire logic [7:0] send_byte, // Byte sent on pcm_in
  input wire logic pcm_out, // Device transmit data
  input wire logic pcm_oe_n, // Device transmit enable
  input wire logic delayed_strobe_out, // Cascade output
  output logic slot_strobe_in, // Strobe or frame pulse
  output logic pcm_in, // Receive data to device
  output logic busy, // Frame in progress
  output logic [7:0] got_byte, // Byte seen on pcm_out
  output logic [39:0] oe_hist, // Enable per falling edge
  output logic [39:0] dly_hist // Cascade level per falling edge
);
  // Idle level first, then the active strobe, 8 data bits, 32 idle bits
  initial
  begin
    slot_strobe_in = 1'h0;
    pcm_in = 1'h0;
    busy = 1'h0;
    forever
    begin
      @(posedge go);
      busy = 1'h1;
      @(negedge bit_clk);
      slot_strobe_in <= bus_mode;
      @(negedge bit_clk);
      slot_strobe_in <= ~bus_mode;
      for (int i = 0; i < 40; i++)
      begin
        @(posedge bit_clk);
        // Released line toggles so a stale bit never passes
        pcm_in <= (i < 8) ? send_byte[7 - i] : ~pcm_in;
        @(negedge bit_clk);
        oe_hist[i] <= pcm_oe_n;
        dly_hist[i] <= delayed_strobe_out;
        if (i < 8)
          got_byte[7 - i] <= pcm_out;
        if (i == (bus_mode ? 0 : 7))
          slot_strobe_in <= bus_mode;
      end
      busy = 1'h0;
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the codec digital ports
`timescale 1ns/1ps
`default_nettype none
module testbench
  import codec_ports_pkg::*;
;
  logic clock, sys_rst, power_up_reset_n, bit_clk, law_drv, host_d1, go, bus_mode;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cs_n, sclk, data2_in, busy;
  logic law_irq_out, law_irq_oe_n, law_is_a, data1_out, data1_oe_n, pcm_out, pcm_oe_n;
  logic delayed_strobe_out, slot_strobe_in, pcm_in, law_pin, data1_in;
  logic [7:0] wb_adr_i, send_byte, got_byte, rx;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [39:0] oe_hist, dly_hist, exp_dly;
  int mismatches, total_checks;

  // Open-drain and two-way pins resolved from every enable
  assign law_pin = law_irq_oe_n ? law_drv : law_irq_out;
  assign data1_in = data1_oe_n ? host_d1 : data1_out;

  codec_digital_ports dut_u (.clock(clock), .sys_rst(sys_rst),
    .power_up_reset_n(power_up_reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .law_irq_in(law_pin),
    .law_irq_out(law_irq_out), .law_irq_oe_n(law_irq_oe_n), .law_is_a(law_is_a),
    .cs_n(cs_n), .sclk(sclk), .data1_in(data1_in), .data1_out(data1_out),
    .data1_oe_n(data1_oe_n), .data2_in(data2_in), .bit_clk(bit_clk),
    .slot_strobe_in(slot_strobe_in), .pcm_in(pcm_in), .pcm_out(pcm_out),
    .pcm_oe_n(pcm_oe_n), .delayed_strobe_out(delayed_strobe_out));

  pcm_far_end far_u (.bit_clk(bit_clk), .go(go), .bus_mode(bus_mode),
    .send_byte(send_byte), .pcm_out(pcm_out), .pcm_oe_n(pcm_oe_n),
    .delayed_strobe_out(delayed_strobe_out), .slot_strobe_in(slot_strobe_in),
    .pcm_in(pcm_in), .busy(busy), .got_byte(got_byte), .oe_hist(oe_hist),
    .dly_hist(dly_hist));

  // System clock, 100 MHz
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Link clock, 32 ns, phase unrelated to the system clock
  initial
  begin
    bit_clk = 1'h0;
    #3.7;
    forever #16 bit_clk = ~bit_clk;
  end

  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 100);
    rd = wb_dat_o;
    if (n >= 100)
      chk("wb_ack", 1'h0, 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 4'hF);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0, 4'hF);
    chk(name, rd, exp);
  endtask

  // One microport byte, MSB first; sclk phases last 6 clocks each
  task automatic up_byte(input logic [7:0] tx, input logic single, input logic cs_lvl);
    cs_n <= cs_lvl;
    for (int i = 7; i >= 0; i--)
    begin
      host_d1 <= tx[i];
      data2_in <= single ? ~tx[i] : tx[i];
      repeat (6) @(posedge clock);
      sclk <= 1'h1;
      rx[i] = data1_in;
      repeat (6) @(posedge clock);
      sclk <= 1'h0;
    end
    repeat (6) @(posedge clock);
    cs_n <= 1'h1;
    repeat (6) @(posedge clock);
  endtask

  // One PCM frame in the given timing mode, both directions checked
  task automatic pcm_frame(input logic bm, input logic [7:0] tx, input logic [7:0] rxb);
    int n;
    wr(ADDR_CTRL, 32'(bm) << CTRL_FP_MODE);
    bus_mode <= bm;
    send_byte <= rxb;
    wr(ADDR_PCM_TX, 32'(tx));
    repeat (20) @(posedge clock);
    go <= 1'h1;
    repeat (4) @(posedge clock);
    go <= 1'h0;
    n = 0;
    while (busy !== 1'h0 && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 2000)
      chk("pcm_busy", 1'h0, 1'h1);
    repeat (10) @(posedge clock);
    exp_dly = bm ? ~(40'h1 << 32) : (40'hFF << 8);
    chk("pcm_out", got_byte, tx);
    chk("pcm_oe_n", oe_hist, 40'hFF_FFFF_FF00);
    rdchk("pcm_rx", ADDR_PCM_RX, 32'(rxb));
    chk("delayed_strobe", dly_hist, exp_dly);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Run needs about 12 us; a hang is cut well beyond that
  initial
  begin
    #500000;
    mismatches++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    // Deselected host, law pin low so reset reads mu-law
    {sys_rst, power_up_reset_n, cs_n, law_drv} = 4'hE;
    {wb_cyc_i, wb_stb_i, wb_we_i, sclk, host_d1, data2_in, go, bus_mode} = 8'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, send_byte} = 52'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clock);
    rdchk("ctrl_rst", ADDR_CTRL, 32'h0);
    rdchk("status_rst", ADDR_STATUS, 32'h0800_0000);
    rdchk("unmapped", 8'h1C, 32'h0);
    wb(1'h1, ADDR_CTRL, 32'h1F, 4'h0);
    rdchk("ctrl_no_lane", ADDR_CTRL, 32'h0);
    $display("test reset defaults done");
    // Pin, law bit and enable combinations
    for (int k = 0; k < 4; k++)
    begin
      law_drv <= k[0];
      wr(ADDR_CTRL, {29'h0, k == 3, 1'h0, k == 2});
      repeat (8) @(posedge clock);
      chk("law_is_a", law_is_a, k == 1 || k == 2);
      rdchk("law_eff", ADDR_STATUS, 32'h0800_0000 | 32'(k == 1 || k == 2));
    end
    $display("test law select done");
    wr(ADDR_CTRL, 32'h08);
    wr(ADDR_UP_TX, 32'hC3);
    up_byte(8'hA5, 1'h0, 1'h0);
    chk("up_split_out", rx, 8'hC3);
    rdchk("up_split_in", ADDR_UP_RX, 32'hA5);
    up_byte(8'h3E, 1'h0, 1'h1);
    chk("up_idle_out", rx, 8'h3E);
    rdchk("up_idle_in", ADDR_UP_RX, 32'hA5);
    wr(ADDR_CTRL, 32'h00);
    up_byte(8'h5A, 1'h1, 1'h0);
    rdchk("up_single_in", ADDR_UP_RX, 32'h5A);
    wr(ADDR_CTRL, 32'h10);
    up_byte(8'h00, 1'h1, 1'h0);
    chk("up_single_out", rx, 8'hC3);
    $display("test microport done");
    wr(ADDR_CTRL, 32'h04);
    up_byte(8'h11, 1'h1, 1'h0);
    chk("irq_strobed", law_irq_oe_n, 1'h1);
    wr(ADDR_CTRL, 32'h06);
    up_byte(8'h22, 1'h1, 1'h0);
    chk("irq_pin", law_irq_oe_n, 1'h0);
    chk("irq_level", law_irq_out, 1'h0);
    rdchk("irq_flag", ADDR_STATUS, 32'h0800_0002);
    wr(ADDR_STATUS, 32'h02);
    repeat (4) @(posedge clock);
    chk("irq_clear", law_irq_oe_n, 1'h1);
    $display("test interrupt done");
    pcm_frame(1'h0, 8'hC3, 8'h96);
    pcm_frame(1'h1, 8'h5A, 8'h69);
    $display("test pcm link done");
    wr(ADDR_CTRL, 32'h1F);
    wr(ADDR_UP_TX, 32'h77);
    power_up_reset_n <= 1'h0;
    repeat (20) @(posedge clock);
    power_up_reset_n <= 1'h1;
    repeat (5) @(posedge clock);
    rdchk("ctrl_pwr", ADDR_CTRL, 32'h0);
    rdchk("up_tx_pwr", ADDR_UP_TX, 32'h0);
    rdchk("pcm_tx_pwr", ADDR_PCM_TX, 32'h0);
    $display("test power-up reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
